// File: rtl/flash_cfg_pkg.sv
package flash_cfg_pkg;

    // Array geometry
    localparam int ADDR_W = 22;
    localparam logic [22:0] MEM_SIZE = 23'h400000;
    localparam int PAGE_MAX = 1024;
    localparam logic [11:0] PAGE_BYTES_STD = 12'h100;
    localparam logic [11:0] PAGE_BYTES_QUAD = 12'h400;
    localparam logic [21:0] MASK_PAGE_STD = 22'h0000ff;
    localparam logic [21:0] MASK_PAGE_QUAD = 22'h0003ff;
    localparam logic [21:0] MASK_SECTOR = 22'h000fff;
    localparam logic [21:0] MASK_BLOCK32 = 22'h007fff;
    localparam logic [21:0] MASK_BLOCK64 = 22'h00ffff;
    localparam logic [21:0] MASK_CHIP = 22'h3fffff;

    // Protection size exponents
    localparam logic [4:0] LOG2_BLOCK_BASE = 5'h0f;
    localparam logic [4:0] LOG2_SUB_BASE = 5'h0b;
    localparam logic [4:0] LOG2_SUB_MAX = 5'h0f;
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_ALL = 3'h7;
    localparam logic [2:0] CODE_SUB_MAX = 3'h4;

    // Command codes
    localparam logic [7:0] CMD_WRITE_ENABLE_COMMAND = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_WRSR = 8'h01;
    localparam logic [7:0] CMD_WRSR2 = 8'h31;
    localparam logic [7:0] CMD_WRCR = 8'h11;
    localparam logic [7:0] CMD_RDSR1 = 8'h05;
    localparam logic [7:0] CMD_RDSR2 = 8'h35;
    localparam logic [7:0] CMD_RDCR_A = 8'h45;
    localparam logic [7:0] CMD_RDCR_B = 8'h15;
    localparam logic [7:0] CMD_PP = 8'h02;
    localparam logic [7:0] CMD_DPP = 8'ha2;
    localparam logic [7:0] CMD_QPP = 8'h32;
    localparam logic [7:0] CMD_PE = 8'h81;
    localparam logic [7:0] CMD_SE = 8'h20;
    localparam logic [7:0] CMD_BE32 = 8'h52;
    localparam logic [7:0] CMD_BE64 = 8'hd8;
    localparam logic [7:0] CMD_CE_A = 8'h60;
    localparam logic [7:0] CMD_CE_B = 8'hc7;
    localparam logic [7:0] CMD_RELEASE_DPD = 8'hb9;
    localparam logic [7:0] CMD_DPD_ENTER = 8'hab;

    // Command lengths in whole bytes
    localparam logic [11:0] LEN_ONE = 12'h001;
    localparam logic [11:0] LEN_TWO = 12'h002;
    localparam logic [11:0] LEN_THREE = 12'h003;
    localparam logic [11:0] LEN_ADDR = 12'h004;
    localparam logic [11:0] LEN_PROG_MIN = 12'h005;
    localparam logic [11:0] LEN_SAT = 12'hfff;

    // Configuration register
    localparam int CR_DC = 0;
    localparam int CR_QP = 4;
    localparam int CR_DRV_LO = 5;
    localparam int CR_DRV_HI = 6;
    localparam logic [7:0] CR_RESET = 8'h60;
    localparam logic [7:0] CR_WMASK = 8'h71;

    // Status register
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 6;
    localparam int SR_STATUS_PROTECT_MODE_LO = 7;
    localparam int SR_STATUS_PROTECT_MODE_HI = 8;
    localparam int SR_CMP = 14;
    localparam logic [15:0] SR_RESET = 16'h0000;
    localparam logic [15:0] SR_WMASK = 16'h43fc;

    // Read drive and dummy encodings
    localparam logic [6:0] DRV_PCT_00 = 7'h50;
    localparam logic [6:0] DRV_PCT_01 = 7'h28;
    localparam logic [6:0] DRV_PCT_10 = 7'h64;
    localparam logic [6:0] DRV_PCT_11 = 7'h3c;
    localparam logic [3:0] DUMMY_2IO_DC0 = 4'h4;
    localparam logic [3:0] DUMMY_2IO_DC1 = 4'h8;
    localparam logic [3:0] DUMMY_4IO_DC0 = 4'h6;
    localparam logic [3:0] DUMMY_4IO_DC1 = 4'ha;

    typedef enum logic {ST_STANDBY, ST_DEEP_PD} power_state_t;

endpackage

// File: rtl/flash_config_and_write_protect.sv
`timescale 1ns/1ps
// Functional notes
// - Quad page bit resets 0, selects 1024-byte page
// - Buffer load wraps at 256 unless quad page
// - Page erase covers 1024 bytes in quad mode
// - Drive field encodes 80/40/100/60 percent, default 11
// - Dual I/O read dummies: 4, or 8
// - Quad I/O read dummies: 6, or 10
// - Power-up returns to standby, no array changes
// - Changing commands must end on byte boundary
// - Write enable latch gates every changing command
// - Low protect pin locks protection bits in hardware mode
// - Deep power-down ignores all but release command
// - Block field selects range; 000 none, 111 all
// - Block codes protect 64KB to 2MB, top or bottom
// - Sub-block codes protect 4KB to 32KB
// - Complement bit inverts the protected range
// - Program or erase touching protection is dropped
// - Chip erase only with nothing protected
// - Hardware mode with pin low locks status register
module flash_config_and_write_protect (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic SI,
    input wire logic WP_N,
    input wire logic ARRAY_BUSY,
    input wire logic [9:0] BUF_RADDR,
    output logic SO,
    output logic SO_OE_N,
    output logic PROG_START,
    output logic ERASE_START,
    output logic REJECT,
    output logic [21:0] OP_LO,
    output logic [21:0] OP_HI,
    output logic [10:0] PROG_COUNT,
    output logic [7:0] BUF_RDATA,
    output logic [7:0] CONFIG_REG,
    output logic [15:0] STATUS_REG,
    output logic PAGE_QUAD,
    output logic [6:0] DRIVE_PCT,
    output logic [3:0] DUMMY_2IO,
    output logic [3:0] DUMMY_4IO,
    output logic DEEP_PD
);
    // Link side, clocked by SCLK
    logic frame_open;
    logic frame_id;
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic [11:0] byte_cnt;
    logic [7:0] cmd;
    logic [23:0] fb;
    logic [7:0] prog_buf [0:flash_cfg_pkg::PAGE_MAX-1];
    logic [2:0] cur_bit;
    logic [11:0] cur_byte;
    logic [11:0] next_byte_cnt;
    logic byte_done;
    logic [7:0] in_byte;
    logic cmd_load;
    logic fb_load;
    logic cmd_is_prog;
    logic buf_we;
    logic [11:0] data_idx;
    logic [9:0] buf_off;
    logic is_rd;
    logic rd_active;
    logic [7:0] rd_byte;
    logic so_q;
    logic so_oe_n_q;

    // Controller side, clocked by MCLK
    logic [2:0] cs_sync;
    logic [2:0] wp_sync;
    logic cs_level;
    logic wp_level;
    logic seen_id;
    logic busy_q;
    logic write_enable_latch;
    logic [15:0] sr_nv;
    logic [7:0] cr;
    flash_cfg_pkg::power_state_t pwr;
    flash_cfg_pkg::power_state_t next_pwr;
    logic cs_rise;
    logic new_frame;
    logic whole;
    logic standby;
    logic [11:0] nb;
    logic is_write_enable_command;
    logic is_wrdi;
    logic is_wrsr;
    logic is_wrcr;
    logic is_prog;
    logic is_erase;
    logic is_chip;
    logic is_change;
    logic sr_locked;
    logic base_ok;
    logic accept_prog;
    logic accept_erase;
    logic accept_wrsr;
    logic accept_wrcr;
    logic accept_change;
    logic go_dpd;
    logic go_release;
    logic next_wel;
    logic [15:0] sr_wdata;
    logic [15:0] sr_mask;
    logic [15:0] next_sr;
    logic [21:0] page_mask;
    logic [21:0] op_mask;
    logic [21:0] op_lo;
    logic [21:0] op_hi;
    logic [11:0] page_bytes;
    logic [11:0] data_bytes;
    logic [11:0] next_count;
    logic [6:0] next_drive;
    logic [15:0] next_status;
    prot_if pif ();

    // Frame framing: CS_N high closes the frame without needing an SCLK edge
    always_ff @(posedge SCLK or posedge CS_N or negedge RST_N) begin
        if (!RST_N) begin
            frame_open <= 1'b0;
        end else if (CS_N) begin
            frame_open <= 1'b0;
        end else begin
            frame_open <= 1'b1;
        end
    end

    assign cur_bit = frame_open ? bit_cnt : 3'h0;
    assign cur_byte = frame_open ? byte_cnt : 12'h000;
    assign byte_done = (cur_bit == 3'h7);
    assign in_byte = {shreg[6:0], SI};
    assign next_byte_cnt = (byte_done && cur_byte != flash_cfg_pkg::LEN_SAT) ?
        cur_byte + 12'h001 : cur_byte;
    assign cmd_load = byte_done && (cur_byte == 12'h000);
    assign fb_load = byte_done && (cur_byte >= flash_cfg_pkg::LEN_ONE) &&
        (cur_byte <= flash_cfg_pkg::LEN_THREE);

    always_ff @(posedge SCLK or negedge RST_N) begin
        if (!RST_N) begin
            shreg <= 8'h00;
            bit_cnt <= 3'h0;
            byte_cnt <= 12'h000;
            frame_id <= 1'b0;
            cmd <= 8'h00;
            fb <= 24'h000000;
        end else begin
            shreg <= in_byte;
            bit_cnt <= cur_bit + 3'h1;
            byte_cnt <= next_byte_cnt;
            frame_id <= frame_open ? frame_id : ~frame_id;
            cmd <= cmd_load ? in_byte : cmd;
            fb <= fb_load ? {fb[15:0], in_byte} : fb;
        end
    end

    // Program buffer load; cr and DEEP_PD only change between frames
    assign cmd_is_prog = (cmd == flash_cfg_pkg::CMD_PP) || (cmd == flash_cfg_pkg::CMD_DPP) ||
        (cmd == flash_cfg_pkg::CMD_QPP);
    assign data_idx = cur_byte - flash_cfg_pkg::LEN_ADDR;
    assign buf_off = cr[flash_cfg_pkg::CR_QP] ? fb[9:0] + data_idx[9:0] :
        {2'b00, fb[7:0] + data_idx[7:0]};
    assign buf_we = byte_done && (cur_byte >= flash_cfg_pkg::LEN_ADDR) && cmd_is_prog &&
        !DEEP_PD;

    always_ff @(posedge SCLK) begin
        if (buf_we) begin
            prog_buf[buf_off] <= in_byte;
        end
    end

    // Register read-out on SO; ignored while powered down
    assign is_rd = (cmd == flash_cfg_pkg::CMD_RDSR1) || (cmd == flash_cfg_pkg::CMD_RDSR2) ||
        (cmd == flash_cfg_pkg::CMD_RDCR_A) || (cmd == flash_cfg_pkg::CMD_RDCR_B);
    assign rd_active = frame_open && (byte_cnt >= flash_cfg_pkg::LEN_ONE) && is_rd &&
        !DEEP_PD;
    assign rd_byte = (cmd == flash_cfg_pkg::CMD_RDSR1) ? STATUS_REG[7:0] :
        (cmd == flash_cfg_pkg::CMD_RDSR2) ? STATUS_REG[15:8] : CONFIG_REG;

    always_ff @(negedge SCLK or posedge CS_N or negedge RST_N) begin
        if (!RST_N) begin
            so_q <= 1'b0;
            so_oe_n_q <= 1'b1;
        end else if (CS_N) begin
            so_q <= 1'b0;
            so_oe_n_q <= 1'b1;
        end else begin
            so_q <= rd_active ? rd_byte[3'h7 - bit_cnt] : so_q;
            so_oe_n_q <= !rd_active;
        end
    end

    assign SO = so_q;
    assign SO_OE_N = so_oe_n_q;

    // Pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cs_sync <= 3'h7;
            wp_sync <= 3'h7;
            cs_level <= 1'b1;
            wp_level <= 1'b1;
        end else begin
            cs_sync <= {cs_sync[1:0], CS_N};
            wp_sync <= {wp_sync[1:0], WP_N};
            cs_level <= (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_level;
            wp_level <= (wp_sync[1] == wp_sync[2]) ? wp_sync[2] : wp_level;
        end
    end

    // Frame fields are held still while CS_N is high, so they are read directly
    assign cs_rise = cs_sync[1] && cs_sync[2] && !cs_level;
    assign new_frame = cs_rise && (frame_id != seen_id);
    assign whole = (bit_cnt == 3'h0);
    assign nb = byte_cnt;
    assign standby = (pwr == flash_cfg_pkg::ST_STANDBY);
    assign is_write_enable_command = (cmd == flash_cfg_pkg::CMD_WRITE_ENABLE_COMMAND) && (nb == flash_cfg_pkg::LEN_ONE);
    assign is_wrdi = (cmd == flash_cfg_pkg::CMD_WRDI) && (nb == flash_cfg_pkg::LEN_ONE);
    assign is_wrsr = ((cmd == flash_cfg_pkg::CMD_WRSR) && ((nb == flash_cfg_pkg::LEN_TWO) ||
        (nb == flash_cfg_pkg::LEN_THREE))) ||
        ((cmd == flash_cfg_pkg::CMD_WRSR2) && (nb == flash_cfg_pkg::LEN_TWO));
    assign is_wrcr = (cmd == flash_cfg_pkg::CMD_WRCR) && (nb == flash_cfg_pkg::LEN_TWO);
    assign is_prog = cmd_is_prog && (nb >= flash_cfg_pkg::LEN_PROG_MIN);
    assign is_erase = ((cmd == flash_cfg_pkg::CMD_PE) || (cmd == flash_cfg_pkg::CMD_SE) ||
        (cmd == flash_cfg_pkg::CMD_BE32) || (cmd == flash_cfg_pkg::CMD_BE64)) &&
        (nb == flash_cfg_pkg::LEN_ADDR);
    assign is_chip = ((cmd == flash_cfg_pkg::CMD_CE_A) || (cmd == flash_cfg_pkg::CMD_CE_B)) &&
        (nb == flash_cfg_pkg::LEN_ONE);
    assign is_change = is_prog || is_erase || is_chip || is_wrsr || is_wrcr;

    // Hardware mode with pin low, lock-down and one-time modes all lock
    assign sr_locked = sr_nv[flash_cfg_pkg::SR_STATUS_PROTECT_MODE_HI] ||
        (sr_nv[flash_cfg_pkg::SR_STATUS_PROTECT_MODE_LO] && !wp_level);

    // Target region of the addressed page, sector, block or chip
    assign page_mask = cr[flash_cfg_pkg::CR_QP] ? flash_cfg_pkg::MASK_PAGE_QUAD :
        flash_cfg_pkg::MASK_PAGE_STD;
    assign op_mask = (is_prog || cmd == flash_cfg_pkg::CMD_PE) ? page_mask :
        (cmd == flash_cfg_pkg::CMD_SE) ? flash_cfg_pkg::MASK_SECTOR :
        (cmd == flash_cfg_pkg::CMD_BE32) ? flash_cfg_pkg::MASK_BLOCK32 :
        (cmd == flash_cfg_pkg::CMD_BE64) ? flash_cfg_pkg::MASK_BLOCK64 :
        flash_cfg_pkg::MASK_CHIP;
    assign op_lo = fb[21:0] & ~op_mask;
    assign op_hi = fb[21:0] | op_mask;

    assign pif.bp = sr_nv[flash_cfg_pkg::SR_BP_HI:flash_cfg_pkg::SR_BP_LO];
    assign pif.cmp = sr_nv[flash_cfg_pkg::SR_CMP];
    assign pif.lo = op_lo;
    assign pif.hi = op_hi;

    protect_range_decoder u_decoder (
        .pif(pif.decoder)
    );

    // Acceptance gates
    assign base_ok = new_frame && whole && standby && write_enable_latch && !busy_q;
    assign accept_prog = base_ok && is_prog && !pif.hit;
    assign accept_erase = base_ok && ((is_erase && !pif.hit) || (is_chip && pif.none));
    assign accept_wrsr = base_ok && is_wrsr && !sr_locked;
    assign accept_wrcr = base_ok && is_wrcr;
    assign accept_change = accept_prog || accept_erase || accept_wrsr || accept_wrcr;
    assign go_dpd = new_frame && whole && (cmd == flash_cfg_pkg::CMD_DPD_ENTER) &&
        (nb == flash_cfg_pkg::LEN_ONE);
    assign go_release = new_frame && whole && (cmd == flash_cfg_pkg::CMD_RELEASE_DPD) &&
        (nb == flash_cfg_pkg::LEN_ONE);
    assign next_wel = accept_change ? 1'b0 :
        (new_frame && whole && standby && is_write_enable_command) ? 1'b1 :
        (new_frame && whole && standby && is_wrdi) ? 1'b0 : write_enable_latch;

    // Status write: one or two bytes, only writable bits move
    assign sr_wdata = (cmd == flash_cfg_pkg::CMD_WRSR2) ? {fb[7:0], 8'h00} :
        (nb == flash_cfg_pkg::LEN_THREE) ? {fb[7:0], fb[15:8]} : {8'h00, fb[7:0]};
    assign sr_mask = flash_cfg_pkg::SR_WMASK &
        ((cmd == flash_cfg_pkg::CMD_WRSR2) ? 16'hff00 :
         (nb == flash_cfg_pkg::LEN_THREE) ? 16'hffff : 16'h00ff);
    assign next_sr = (sr_nv & ~sr_mask) | (sr_wdata & sr_mask);

    assign page_bytes = cr[flash_cfg_pkg::CR_QP] ? flash_cfg_pkg::PAGE_BYTES_QUAD :
        flash_cfg_pkg::PAGE_BYTES_STD;
    assign data_bytes = nb - flash_cfg_pkg::LEN_ADDR;
    assign next_count = (data_bytes > page_bytes) ? page_bytes : data_bytes;
    assign next_drive = cr[flash_cfg_pkg::CR_DRV_HI] ?
        (cr[flash_cfg_pkg::CR_DRV_LO] ? flash_cfg_pkg::DRV_PCT_11 : flash_cfg_pkg::DRV_PCT_10) :
        (cr[flash_cfg_pkg::CR_DRV_LO] ? flash_cfg_pkg::DRV_PCT_01 : flash_cfg_pkg::DRV_PCT_00);
    assign next_status = {sr_nv[15:2], write_enable_latch, busy_q};

    always_comb begin
        next_pwr = pwr;
        unique case (pwr)
            flash_cfg_pkg::ST_STANDBY: begin
                if (go_dpd) begin
                    next_pwr = flash_cfg_pkg::ST_DEEP_PD;
                end
            end
            flash_cfg_pkg::ST_DEEP_PD: begin
                if (go_release) begin
                    next_pwr = flash_cfg_pkg::ST_STANDBY;
                end
            end
        endcase
    end

    // Control state; reset lands in standby with the latch clear
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pwr <= flash_cfg_pkg::ST_STANDBY;
            write_enable_latch <= 1'b0;
            seen_id <= 1'b0;
            busy_q <= 1'b0;
            sr_nv <= flash_cfg_pkg::SR_RESET;
            cr <= flash_cfg_pkg::CR_RESET;
        end else begin
            pwr <= next_pwr;
            write_enable_latch <= next_wel;
            seen_id <= cs_rise ? frame_id : seen_id;
            busy_q <= ARRAY_BUSY;
            sr_nv <= accept_wrsr ? next_sr : sr_nv;
            cr <= accept_wrcr ? (fb[7:0] & flash_cfg_pkg::CR_WMASK) : cr;
        end
    end

    // Array requests
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PROG_START <= 1'b0;
            ERASE_START <= 1'b0;
            REJECT <= 1'b0;
            OP_LO <= 22'h000000;
            OP_HI <= 22'h000000;
            PROG_COUNT <= 11'h000;
        end else begin
            PROG_START <= accept_prog;
            ERASE_START <= accept_erase;
            REJECT <= new_frame && standby && is_change && !accept_change;
            OP_LO <= (accept_prog || accept_erase) ? op_lo : OP_LO;
            OP_HI <= (accept_prog || accept_erase) ? op_hi : OP_HI;
            PROG_COUNT <= accept_prog ? next_count[10:0] : PROG_COUNT;
        end
    end

    // Decoded settings; outputs lag the registers by one MCLK, except DEEP_PD, which changes with pwr
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CONFIG_REG <= flash_cfg_pkg::CR_RESET;
            STATUS_REG <= flash_cfg_pkg::SR_RESET;
            PAGE_QUAD <= 1'b0;
            DRIVE_PCT <= flash_cfg_pkg::DRV_PCT_11;
            DUMMY_2IO <= flash_cfg_pkg::DUMMY_2IO_DC0;
            DUMMY_4IO <= flash_cfg_pkg::DUMMY_4IO_DC0;
            DEEP_PD <= 1'b0;
            BUF_RDATA <= 8'h00;
        end else begin
            CONFIG_REG <= cr;
            STATUS_REG <= next_status;
            PAGE_QUAD <= cr[flash_cfg_pkg::CR_QP];
            DRIVE_PCT <= next_drive;
            DUMMY_2IO <= cr[flash_cfg_pkg::CR_DC] ? flash_cfg_pkg::DUMMY_2IO_DC1 :
                flash_cfg_pkg::DUMMY_2IO_DC0;
            DUMMY_4IO <= cr[flash_cfg_pkg::CR_DC] ? flash_cfg_pkg::DUMMY_4IO_DC1 :
                flash_cfg_pkg::DUMMY_4IO_DC0;
            DEEP_PD <= (next_pwr == flash_cfg_pkg::ST_DEEP_PD);
            BUF_RDATA <= prog_buf[BUF_RADDR];
        end
    end
endmodule

// File: rtl/prot_if.sv
`timescale 1ns/1ps
interface prot_if;
    logic [4:0] bp;
    logic cmp;
    logic [21:0] lo;
    logic [21:0] hi;
    logic hit;
    logic none;

    modport decoder (
        input bp,
        input cmp,
        input lo,
        input hi,
        output hit,
        output none
    );

    modport user (
        output bp,
        output cmp,
        output lo,
        output hi,
        input hit,
        input none
    );
endinterface

// File: rtl/protect_range_decoder.sv
`timescale 1ns/1ps
module protect_range_decoder (
    prot_if.decoder pif
);
    logic [2:0] code;
    logic base_empty;
    logic base_all;
    logic [4:0] size_log;
    logic [22:0] size;
    logic [22:0] plo_w;
    logic [22:0] phi_w;
    logic [21:0] plo;
    logic [21:0] phi;
    logic in_base;
    logic outside_base;

    assign code = pif.bp[2:0];
    assign base_empty = (code == flash_cfg_pkg::CODE_NONE);
    assign base_all = (code == flash_cfg_pkg::CODE_ALL);
    // Whole blocks from 64KB upward, or sub-blocks capped at 32KB
    assign size_log = pif.bp[4] ?
        ((code >= flash_cfg_pkg::CODE_SUB_MAX) ? flash_cfg_pkg::LOG2_SUB_MAX :
         flash_cfg_pkg::LOG2_SUB_BASE + {2'b00, code}) :
        flash_cfg_pkg::LOG2_BLOCK_BASE + {2'b00, code};
    assign size = 23'h000001 << size_log;
    assign plo_w = pif.bp[3] ? 23'h000000 : flash_cfg_pkg::MEM_SIZE - size;
    assign phi_w = plo_w + size - 23'h000001;
    assign plo = plo_w[21:0];
    assign phi = phi_w[21:0];
    assign in_base = (pif.lo <= phi) && (pif.hi >= plo);
    assign outside_base = (pif.lo < plo) || (pif.hi > phi);

    // Complement protects everything outside the base range
    assign pif.hit = pif.cmp ?
        (base_empty | (!base_all & outside_base)) :
        (!base_empty & (base_all | in_base));
    assign pif.none = pif.cmp ? base_all : base_empty;
endmodule

// File: tb/flash_cfg_chk.sv
`timescale 1ns/1ps
module flash_cfg_chk (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic WP_N,
    input wire logic PROG_START,
    input wire logic ERASE_START,
    input wire logic REJECT,
    input wire logic [21:0] OP_LO,
    input wire logic [21:0] OP_HI,
    input wire logic [7:0] CONFIG_REG,
    input wire logic [15:0] STATUS_REG,
    input wire logic PAGE_QUAD,
    input wire logic [6:0] DRIVE_PCT,
    input wire logic [3:0] DUMMY_2IO,
    input wire logic [3:0] DUMMY_4IO,
    input wire logic DEEP_PD
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    wire [1:0] drv = CONFIG_REG[6:5];
    wire [6:0] drv_exp = drv[1] ? (drv[0] ? 7'h3c : 7'h64) : (drv[0] ? 7'h28 : 7'h50);
    wire starts = PROG_START || ERASE_START;
    wire none_prot = STATUS_REG[14] ? STATUS_REG[4:2] == 3'h7 : STATUS_REG[4:2] == 3'h0;
    // Sync chain is three flops, so five low samples cover it
    sequence wp_low_held;
        !WP_N [*5] ##0 STATUS_REG[8:7] == 2'b01;
    endsequence
    sequence dpd_held;
        DEEP_PD [*2];
    endsequence
    AST_CR_RESERVED: assert property ((CONFIG_REG & 8'h8e) == 8'h00)
        else $error("reserved config bits set");
    AST_QUAD_PAGE: assert property (PAGE_QUAD == CONFIG_REG[4])
        else $error("page size level wrong");
    AST_DRIVE_MAP: assert property ($stable(CONFIG_REG) |-> DRIVE_PCT == drv_exp)
        else $error("drive strength wrong");
    AST_DUAL_DUMMY: assert property ($stable(CONFIG_REG) |-> DUMMY_2IO == (CONFIG_REG[0] ? 4'h8 : 4'h4))
        else $error("dual dummy count wrong");
    AST_QUAD_DUMMY: assert property ($stable(CONFIG_REG) |-> DUMMY_4IO == (CONFIG_REG[0] ? 4'ha : 4'h6))
        else $error("quad dummy count wrong");
    // Status shows the latch one cycle behind the start pulse
    AST_WEL_CONSUMED: assert property (starts |-> STATUS_REG[1] ##1 !STATUS_REG[1])
        else $error("operation without write enable");
    AST_NO_LOCK_OP: assert property (REJECT |-> !starts)
        else $error("refused operation started");
    AST_CHIP_GUARD: assert property (ERASE_START && OP_LO == 22'h0 && OP_HI == 22'h3fffff |-> none_prot)
        else $error("chip erase while protected");
    AST_DPD_QUIET: assert property (dpd_held |-> !starts && !REJECT)
        else $error("command acted on in power-down");
    AST_HW_LOCK: assert property (wp_low_held |=> $stable(STATUS_REG[15:2]))
        else $error("status written while pin locked");
endmodule

bind flash_config_and_write_protect flash_cfg_chk chk_u (
    .MCLK, .RST_N, .WP_N, .PROG_START, .ERASE_START, .REJECT, .OP_LO, .OP_HI,
    .CONFIG_REG, .STATUS_REG, .PAGE_QUAD, .DRIVE_PCT, .DUMMY_2IO, .DUMMY_4IO, .DEEP_PD
);

// File: tb/flash_config_and_write_protect_test.sv
`timescale 1ns/1ps
module flash_config_and_write_protect_test;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic WP_N = 1'b1;
    logic ARRAY_BUSY = 1'b0;
    logic [9:0] BUF_RADDR = 10'h000;
    logic go = 1'b0;
    logic [63:0] tx = 64'h0;
    logic [6:0] nbits = 7'h00;
    wire SCLK, CS_N, SI, SO, SO_OE_N, PROG_START, ERASE_START, REJECT, DEEP_PD, PAGE_QUAD, busy;
    wire [21:0] OP_LO, OP_HI;
    wire [10:0] PROG_COUNT;
    wire [7:0] BUF_RDATA, CONFIG_REG, rx;
    wire [15:0] STATUS_REG;
    wire [6:0] DRIVE_PCT;
    wire [3:0] DUMMY_2IO, DUMMY_4IO;
    int failures = 0, total_checks = 0, n_acc = 0, n_rej = 0, a0, r0, k;
    logic [6:0] drv_tab [4] = '{7'h50, 7'h28, 7'h64, 7'h3c};
    logic [15:0] pt_sr [9] = '{16'h4, 16'h4, 16'h24, 16'h44, 16'h44, 16'h54, 16'h1c, 16'h4004,
        16'h4004};
    logic [23:0] pt_a [9] = '{24'h3f0000, 24'h3e0000, 24'h0, 24'h3ff000, 24'h3fe000, 24'h3f7000,
        24'h0, 24'h3ef000, 24'h3f0000};
    int pt_ok [9] = '{0, 1, 0, 0, 1, 1, 0, 0, 1};
    spi_host_model host_u (.go(go), .tx(tx), .nbits(nbits), .so(SO), .sclk(SCLK), .cs_n(CS_N),
        .si(SI), .busy(busy), .rx(rx));
    flash_config_and_write_protect dut_u (.MCLK, .RST_N, .SCLK, .CS_N, .SI, .WP_N, .ARRAY_BUSY,
        .BUF_RADDR, .SO, .SO_OE_N, .PROG_START, .ERASE_START, .REJECT, .OP_LO, .OP_HI,
        .PROG_COUNT, .BUF_RDATA, .CONFIG_REG, .STATUS_REG, .PAGE_QUAD, .DRIVE_PCT, .DUMMY_2IO,
        .DUMMY_4IO, .DEEP_PD);
    always #5 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        n_acc <= n_acc + int'(PROG_START === 1'b1 || ERASE_START === 1'b1);
        n_rej <= n_rej + int'(REJECT === 1'b1);
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Rej below zero skips the refusal count
    task automatic send(input logic [63:0] d, input int n, input int acc, input int rej);
        int w;
        a0 = n_acc;
        r0 = n_rej;
        tx <= d;
        nbits <= 7'(n);
        go <= 1'b1;
        @(posedge MCLK) go <= 1'b0;
        for (w = 0; busy !== 1'b0; w++) begin
            if (w == 100) begin
                failures++;
                report_and_stop;
            end
            @(posedge MCLK);
        end
        repeat (8) @(posedge MCLK);
        chk(n_acc - a0, acc);
        if (rej >= 0)
            chk(n_rej - r0, rej);
    endtask
    task automatic write_enable_command;
        send({8'h06, 56'h0}, 8, 0, 0);
    endtask
    task automatic wrsr(input logic [15:0] v, input int ok);
        write_enable_command;
        send({8'h01, v[7:0], v[15:8], 40'h0}, 24, 0, 1 - ok);
    endtask
    task automatic rdbuf(input logic [9:0] a, input logic [7:0] e);
        BUF_RADDR <= a;
        repeat (3) @(posedge MCLK);
        chk(BUF_RDATA, e);
    endtask
    initial begin
        repeat (6) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge MCLK);
        chk({CONFIG_REG, DRIVE_PCT}, {8'h60, 7'h3c});
        chk({PAGE_QUAD, DUMMY_2IO, DUMMY_4IO}, {1'b0, 8'h46});
        chk({STATUS_REG, DEEP_PD}, 17'h0);
        send({8'h81, 24'h000100, 32'h0}, 32, 0, 1);
        write_enable_command;
        send({8'h20, 56'h0}, 33, 0, -1);
        chk(STATUS_REG[1], 1);
        send({8'h02, 24'h0000fe, 24'haabbcc, 8'h0}, 56, 1, 0);
        chk(PROG_COUNT, 3);
        rdbuf(10'h000, 8'hcc);
        for (k = 0; k < 4; k++) begin
            write_enable_command;
            send({8'h11, 1'b1, k[1:0], k[0], 3'b111, k[1], 48'h0}, 16, 0, 0);
            chk(CONFIG_REG, {1'b0, k[1:0], k[0], 3'b000, k[1]});
            chk(DRIVE_PCT, drv_tab[k]);
            chk({PAGE_QUAD, DUMMY_2IO, DUMMY_4IO}, {k[0], k[1] ? 8'h8a : 8'h46});
        end
        write_enable_command;
        send({8'h81, 24'h123456, 32'h0}, 32, 1, 0);
        chk({OP_LO, OP_HI}, {22'h123400, 22'h1237ff});
        write_enable_command;
        send({8'h02, 24'h0000ff, 16'h1122, 16'h0}, 48, 1, 0);
        rdbuf(10'h100, 8'h22);
        for (k = 0; k < 9; k++) begin
            wrsr(pt_sr[k], 1);
            chk(STATUS_REG & 16'hfffc, pt_sr[k]);
            write_enable_command;
            send({8'h20, pt_a[k], 32'h0}, 32, pt_ok[k], 1 - pt_ok[k]);
        end
        write_enable_command;
        send({8'h60, 56'h0}, 8, 0, 1);
        wrsr(16'h401c, 1);
        write_enable_command;
        send({8'hc7, 56'h0}, 8, 1, 0);
        WP_N <= 1'b0;
        wrsr(16'h0080, 1);
        wrsr(16'h0004, 0);
        chk(STATUS_REG[15:2], 14'h0020);
        WP_N <= 1'b1;
        wrsr(16'h0000, 1);
        chk(STATUS_REG, 16'h0000);
        send({8'hab, 56'h0}, 8, 0, 0);
        chk(DEEP_PD, 1);
        write_enable_command;
        chk(STATUS_REG[1], 0);
        send({8'hb9, 56'h0}, 8, 0, 0);
        chk(DEEP_PD, 0);
        write_enable_command;
        send({8'h05, 56'h0}, 16, 0, 0);
        chk(rx, 8'h02);
        report_and_stop;
    end
endmodule

// File: tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    input wire logic go,
    input wire logic [63:0] tx,
    input wire logic [6:0] nbits,
    input wire logic so,
    output logic sclk,
    output logic cs_n,
    output logic si,
    output logic busy,
    output logic [7:0] rx
);
    int i;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
        busy = 1'b0;
        rx = 8'h00;
    end
    // Mode 0, MSB first, clock still between frames
    // No dual or quad fast reads issued at this clock rate
    always @(posedge go) begin
        busy = 1'b1;
        #1 cs_n = 1'b0;
        for (i = 0; i < nbits; i++) begin
            si = tx[63 - i];
            #3 sclk = 1'b1;
            rx = {rx[6:0], so};
            #3 sclk = 1'b0;
        end
        #3 cs_n = 1'b1;
        // Released line must not keep the last bit
        si = ~si;
        #50 busy = 1'b0;
    end
endmodule
